// >>> logic/fol_pkg.sv
// shared constants and types for the flash command sequencer and option loader
// assumes a 125 MHz system clock and an axi4-lite register master
package fol_pkg;

    // register byte offsets
    localparam logic [11:0] CMD_OFS       = 12'hFF8;
    localparam logic [11:0] PROG_ADDR_OFS = 12'hFF0;
    localparam logic [11:0] PROG_DATA_OFS = 12'hFF4;

    // command codes
    localparam logic [7:0] CODE_UNLOCK1    = 8'h73;
    localparam logic [7:0] CODE_UNLOCK2    = 8'h8C;
    localparam logic [7:0] CODE_PAGE_ERASE = 8'h95;
    localparam logic [7:0] CODE_MASS_ERASE = 8'h63;
    localparam logic [7:0] CMD_RESET       = 8'h00;

    // option byte location and layout, protection bits are active low so an erased byte is unprotected
    localparam logic [15:0] OPT_ADDR          = 16'h0000;
    localparam logic [15:0] PROG_ADDR_RESET   = 16'h0000;
    localparam int          OPT_WDT_INT_BIT   = 0;
    localparam int          OPT_WDT_RUN_BIT   = 1;
    localparam int          OPT_RD_PROT_N_BIT = 2;
    localparam int          OPT_WP_ALL_N_BIT  = 3;
    localparam int          OPT_WP_LOW_N_BIT  = 4;
    localparam logic [7:0]  OPT_RESET         = 8'hFF;

    // status byte layout
    localparam int ST_STATE_LSB   = 0;
    localparam int ST_BUSY_BIT    = 2;
    localparam int ST_REFUSED_BIT = 3;

    // operation timing
    localparam int CLK_PERIOD_NS       = 8;
    localparam int PROG_TIME_NS        = 40000;
    localparam int PAGE_ERASE_TIME_NS  = 10000000;
    localparam int MASS_ERASE_TIME_NS  = 100000000;
    localparam int PROG_CYCLES         = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAGE_ERASE_CYCLES   = (PAGE_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MASS_ERASE_CYCLES   = (MASS_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {SEQ_LOCKED, SEQ_FIRST, SEQ_UNLOCKED, SEQ_BUSY} fol_seq_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        prog;
        logic        pageErase;
        logic        massErase;
    } fol_arr_op_t;

    typedef struct packed {
        logic wdtIntMode;
        logic wdtRunAtReset;
        logic readProtect;
        logic progProtectAll;
        logic progProtectLow;
    } fol_opt_t;

endpackage

// >>> logic/fol_op_timer.sv
// down counter timing one flash array operation
// assumes start is a one-cycle pulse with a nonzero cycle count
`timescale 1ns/1ns
module fol_op_timer #(
    parameter int CNT_W = 32
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] cycles,
    output logic                  running,
    output logic                  done
);
    logic [CNT_W-1:0] cnt_r;
    logic             running_r;
    logic             done_r;
    wire              lastCycle = running_r && (cnt_r == CNT_W'(1));

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            cnt_r     <= '0;
            running_r <= 1'b0;
            done_r    <= 1'b0;
        end
        else
        begin
            done_r <= lastCycle;
            if (start)
            begin
                cnt_r     <= cycles;
                running_r <= 1'b1;
            end
            else if (running_r)
            begin
                cnt_r     <= cnt_r - CNT_W'(1);
                running_r <= !lastCycle;
            end
        end
    end

    assign running = running_r;
    assign done    = done_r;
endmodule

// >>> logic/fol_option_loader.sv
// reads the option byte from program memory after every reset kind
// assumes the array returns read data one cycle after optRdEn
`timescale 1ns/1ns
module fol_option_loader (
    input  wire logic           clock,
    input  wire logic           resetn,
    input  wire logic           restart,
    input  wire logic [7:0]     arrRdata,
    output logic                optRdEn,
    output logic [15:0]         optRdAddr,
    output fol_pkg::fol_opt_t   options,
    output logic                loading
);
    typedef enum logic [1:0] {LD_ISSUE, LD_WAIT, LD_DONE} fol_ld_t;

    fol_ld_t           st_r;
    logic              rdEn_r;
    fol_pkg::fol_opt_t opt_r;
    logic              loading_r;

    // memory bits for protection are active low so an erased byte leaves code open
    function automatic fol_pkg::fol_opt_t decodeOpt(input logic [7:0] b);
        decodeOpt.wdtIntMode     = b[fol_pkg::OPT_WDT_INT_BIT];
        decodeOpt.wdtRunAtReset  = b[fol_pkg::OPT_WDT_RUN_BIT];
        decodeOpt.readProtect    = !b[fol_pkg::OPT_RD_PROT_N_BIT];
        decodeOpt.progProtectAll = !b[fol_pkg::OPT_WP_ALL_N_BIT];
        decodeOpt.progProtectLow = !b[fol_pkg::OPT_WP_LOW_N_BIT];
    endfunction

    // only this process ever writes opt_r, so a later reprogram waits for a reset
    always_ff @(posedge clock)
    begin
        if (!resetn || restart)
        begin
            st_r      <= LD_ISSUE;
            rdEn_r    <= 1'b0;
            loading_r <= 1'b1;
            // a short reset keeps the old options until the reload lands
            if (!resetn)
                opt_r <= decodeOpt(fol_pkg::OPT_RESET);
        end
        else
        begin
            unique case (st_r)
                LD_ISSUE:
                begin
                    rdEn_r <= 1'b1;
                    st_r   <= LD_WAIT;
                end
                LD_WAIT:
                begin
                    rdEn_r <= 1'b0;
                    if (!rdEn_r)
                    begin
                        opt_r                <= decodeOpt(arrRdata);
                        loading_r            <= 1'b0;
                        st_r                 <= LD_DONE;
                    end
                end
                LD_DONE:
                begin
                    rdEn_r <= 1'b0;
                end
            endcase
        end
    end

    assign optRdEn   = rdEn_r;
    assign optRdAddr = fol_pkg::OPT_ADDR;
    assign options   = opt_r;
    assign loading   = loading_r;
endmodule

// >>> logic/fol_flash_seq.sv
// flash command sequencer with axi4-lite registers and reset-time option loading
// assumes a flash array that acts on level op controls and answers reads a cycle later
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

module fol_flash_seq #(
    parameter int PROG_CYCLES       = fol_pkg::PROG_CYCLES,
    parameter int PAGE_ERASE_CYCLES = fol_pkg::PAGE_ERASE_CYCLES,
    parameter int MASS_ERASE_CYCLES = fol_pkg::MASS_ERASE_CYCLES,
    parameter int PAGE_LSB          = 9
) (
    input  wire logic                  clock,
    input  wire logic                  resetn,
    input  wire logic                  shortResetReq,
    input  wire logic                  stopRecoverReq,
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output fol_pkg::fol_arr_op_t       arrOp,
    output logic                       optRdEn,
    output logic [15:0]                optRdAddr,
    input  wire logic [7:0]            arrRdata,
    output fol_pkg::fol_opt_t          options,
    output logic                       cpuHoldReset
);
    function automatic logic hitOfs(input logic [11:0] a, input logic [11:0] ofs);
        hitOfs = (a[11:2] == ofs[11:2]);
    endfunction

    logic                 awHeld_r;
    logic                 wHeld_r;
    logic                 awready_r;
    logic                 wready_r;
    logic                 bvalid_r;
    logic [1:0]           bresp_r;
    logic                 arready_r;
    logic                 rvalid_r;
    logic [1:0]           rresp_r;
    logic [31:0]          rdata_r;
    logic [11:0]          awAddr_r;
    logic [7:0]           wByte_r;
    logic [15:0]          wHalf_r;
    logic                 wLane0_r;
    fol_pkg::fol_seq_t    seq_r;
    fol_pkg::fol_seq_t    seq_nxt;
    logic [7:0]           cmdReg_r;
    logic [15:0]          progAddr_r;
    logic [7:0]           progData_r;
    logic                 refused_r;
    fol_pkg::fol_arr_op_t arrOp_r;
    logic                 timerStart_r;
    logic [31:0]          timerCycles_r;
    logic                 timerRunning;
    logic                 timerDone;
    logic                 loading;

    // short reset and stop recovery act like reset on the sequencer, array op and op timer
    wire anyReset = !resetn || shortResetReq || stopRecoverReq;

    // write channel: address and data taken in either order
    wire awTake  = s_axi_awvalid && awready_r;
    wire wTake   = s_axi_wvalid && wready_r;
    wire doWrite = awHeld_r && wHeld_r && !bvalid_r;
    wire bDone   = bvalid_r && s_axi_bready;
    wire wrCmd   = doWrite && wLane0_r && hitOfs(awAddr_r, fol_pkg::CMD_OFS);
    wire wrAddr  = doWrite && hitOfs(awAddr_r, fol_pkg::PROG_ADDR_OFS);
    wire wrData  = doWrite && wLane0_r && hitOfs(awAddr_r, fol_pkg::PROG_DATA_OFS);
    wire wrMapped = hitOfs(awAddr_r, fol_pkg::CMD_OFS) || hitOfs(awAddr_r, fol_pkg::PROG_ADDR_OFS)
                    || hitOfs(awAddr_r, fol_pkg::PROG_DATA_OFS);

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            awHeld_r  <= 1'b0;
            wHeld_r   <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= fol_pkg::RESP_OKAY;
            awAddr_r  <= 12'h000;
            wByte_r   <= 8'h00;
            wHalf_r   <= 16'h0000;
            wLane0_r  <= 1'b0;
        end
        else
        begin
            if (awTake)
            begin
                awHeld_r  <= 1'b1;
                awready_r <= 1'b0;
                awAddr_r  <= s_axi_awaddr;
            end
            if (wTake)
            begin
                wHeld_r  <= 1'b1;
                wready_r <= 1'b0;
                wByte_r  <= s_axi_wdata[7:0];
                wHalf_r  <= s_axi_wdata[15:0];
                wLane0_r <= s_axi_wstrb[0];
            end
            if (doWrite)
            begin
                bvalid_r <= 1'b1;
                bresp_r  <= wrMapped ? fol_pkg::RESP_OKAY : fol_pkg::RESP_SLVERR;
                awHeld_r <= 1'b0;
                wHeld_r  <= 1'b0;
            end
            if (bDone)
            begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // read channel; option bytes have no address here, so software never sees them
    wire arTake = s_axi_arvalid && arready_r;
    wire [7:0] statusByte = {4'h0, refused_r, (seq_r == fol_pkg::SEQ_BUSY), 2'(seq_r)};
    wire rdCmd  = hitOfs(s_axi_araddr, fol_pkg::CMD_OFS);
    wire rdAddr = hitOfs(s_axi_araddr, fol_pkg::PROG_ADDR_OFS);
    wire rdData = hitOfs(s_axi_araddr, fol_pkg::PROG_DATA_OFS);
    wire [31:0] rdMux = rdCmd  ? {24'h00_0000, statusByte} :
                        rdAddr ? {16'h0000, progAddr_r} :
                        rdData ? {24'h00_0000, progData_r} : 32'h0000_0000;

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= fol_pkg::RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
        end
        else if (arTake)
        begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rdMux;
            rresp_r   <= (rdCmd || rdAddr || rdData) ? fol_pkg::RESP_OKAY : fol_pkg::RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready)
        begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // protection from the loaded options; the low half counts as the protected part
    wire progBlocked = options.progProtectAll || (options.progProtectLow && !progAddr_r[15]);
    wire isPage      = wrCmd && (wByte_r == fol_pkg::CODE_PAGE_ERASE);
    wire isMass      = wrCmd && (wByte_r == fol_pkg::CODE_MASS_ERASE);
    wire startPage   = (seq_r == fol_pkg::SEQ_UNLOCKED) && isPage && !progBlocked;
    wire startMass   = (seq_r == fol_pkg::SEQ_UNLOCKED) && isMass && !options.progProtectAll;
    wire startProg   = (seq_r == fol_pkg::SEQ_UNLOCKED) && wrData && !progBlocked;
    wire protRefuse  = (seq_r == fol_pkg::SEQ_UNLOCKED) && ((isPage && progBlocked)
                       || (isMass && options.progProtectAll) || (wrData && progBlocked));
    wire startAny    = startPage || startMass || startProg;

    always_comb
    begin
        seq_nxt = seq_r;
        unique case (seq_r)
            fol_pkg::SEQ_LOCKED:
            begin
                if (wrCmd && wByte_r == fol_pkg::CODE_UNLOCK1)
                    seq_nxt = fol_pkg::SEQ_FIRST;
            end
            fol_pkg::SEQ_FIRST:
            begin
                if (wrCmd)
                    seq_nxt = (wByte_r == fol_pkg::CODE_UNLOCK2) ? fol_pkg::SEQ_UNLOCKED : fol_pkg::SEQ_LOCKED;
            end
            fol_pkg::SEQ_UNLOCKED:
            begin
                if (startAny)
                    seq_nxt = fol_pkg::SEQ_BUSY;
                else if (wrCmd || protRefuse)
                    seq_nxt = fol_pkg::SEQ_LOCKED;
            end
            fol_pkg::SEQ_BUSY:
            begin
                // commands during an operation are dropped; byte program keeps the unlock
                if (timerDone)
                    seq_nxt = arrOp_r.prog ? fol_pkg::SEQ_UNLOCKED : fol_pkg::SEQ_LOCKED;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (anyReset)
        begin
            seq_r     <= fol_pkg::SEQ_LOCKED;
            cmdReg_r  <= fol_pkg::CMD_RESET;
            refused_r <= 1'b0;
        end
        else
        begin
            seq_r <= seq_nxt;
            if (wrCmd && seq_r != fol_pkg::SEQ_BUSY)
                cmdReg_r <= wByte_r;
            if (protRefuse)
                refused_r <= 1'b1;
            else if (startAny)
                refused_r <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            progAddr_r <= fol_pkg::PROG_ADDR_RESET;
            progData_r <= 8'h00;
        end
        else if (seq_r != fol_pkg::SEQ_BUSY)
        begin
            if (wrAddr)
                progAddr_r <= wHalf_r;
            if (wrData)
                progData_r <= wByte_r;
        end
    end

    // array op levels held for the whole timed operation
    always_ff @(posedge clock)
    begin
        if (anyReset)
        begin
            arrOp_r       <= '0;
            timerStart_r  <= 1'b0;
            timerCycles_r <= 32'h0000_0000;
        end
        else
        begin
            timerStart_r <= startAny;
            if (startAny)
            begin
                arrOp_r.addr      <= startPage ? {progAddr_r[15:PAGE_LSB], PAGE_LSB'(0)} : progAddr_r;
                arrOp_r.wdata     <= wByte_r;
                arrOp_r.prog      <= startProg;
                arrOp_r.pageErase <= startPage;
                arrOp_r.massErase <= startMass;
                timerCycles_r     <= startProg ? 32'(PROG_CYCLES) :
                                     startPage ? 32'(PAGE_ERASE_CYCLES) : 32'(MASS_ERASE_CYCLES);
            end
            else if (timerDone)
                arrOp_r <= '0;
        end
    end

    fol_op_timer #(
        .CNT_W (32)
    ) u_timer (
        .clock   (clock),
        .resetn  (!anyReset),
        .start   (timerStart_r),
        .cycles  (timerCycles_r),
        .running (timerRunning),
        .done    (timerDone)
    );

    fol_option_loader u_loader (
        .clock     (clock),
        .resetn    (resetn),
        .restart   (shortResetReq || stopRecoverReq),
        .arrRdata  (arrRdata),
        .optRdEn   (optRdEn),
        .optRdAddr (optRdAddr),
        .options   (options),
        .loading   (loading)
    );

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;
    assign arrOp         = arrOp_r;
    assign cpuHoldReset  = loading;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    property p_locked_no_op;
        (seq_r != fol_pkg::SEQ_UNLOCKED) |=> !timerStart_r;
    endproperty
    a_locked_no_op: assert property (p_locked_no_op) else $error("op started while locked");

    property p_unlock_pair;
        (seq_r == fol_pkg::SEQ_UNLOCKED) && $past(seq_r) == fol_pkg::SEQ_FIRST
            |-> $past(wrCmd) && $past(wByte_r) == fol_pkg::CODE_UNLOCK2;
    endproperty
    a_unlock_pair: assert property (p_unlock_pair) else $error("unlock without second code");

    property p_page_start;
        startPage && !anyReset |=> arrOp_r.pageErase && !arrOp_r.massErase && seq_r == fol_pkg::SEQ_BUSY;
    endproperty
    a_page_start: assert property (p_page_start) else $error("page erase not started");

    property p_mass_start;
        startMass && !anyReset |=> arrOp_r.massErase ##1 timerRunning;
    endproperty
    a_mass_start: assert property (p_mass_start) else $error("mass erase not started");

    property p_bad_locks;
        (seq_r == fol_pkg::SEQ_FIRST) && wrCmd && wByte_r != fol_pkg::CODE_UNLOCK2 && !anyReset
            |=> seq_r == fol_pkg::SEQ_LOCKED;
    endproperty
    a_bad_locks: assert property (p_bad_locks) else $error("bad code did not lock");

    property p_status_read;
        arTake && rdCmd |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(statusByte);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status not returned");

    property p_busy_ignores;
        (seq_r == fol_pkg::SEQ_BUSY) && !timerDone && !anyReset |=> seq_r == fol_pkg::SEQ_BUSY && $stable(cmdReg_r);
    endproperty
    a_busy_ignores: assert property (p_busy_ignores) else $error("busy sequencer moved");

    property p_opt_stable;
        !loading && !shortResetReq && !stopRecoverReq |=> $stable(options);
    endproperty
    a_opt_stable: assert property (p_opt_stable) else $error("options changed without reset");

    property p_reload_holds;
        shortResetReq |=> cpuHoldReset ##[1:4] !cpuHoldReset || shortResetReq || stopRecoverReq;
    endproperty
    a_reload_holds: assert property (p_reload_holds) else $error("reload did not finish");

    c_unlock: cover property (seq_r == fol_pkg::SEQ_FIRST ##1 seq_r == fol_pkg::SEQ_UNLOCKED);
    c_page:   cover property (startPage);
    c_mass:   cover property (startMass);
    c_prog_done: cover property (arrOp_r.prog ##1 timerDone);
endmodule

// >>> verification/fol_flash_model.sv
// flash array stand-in: answers option byte reads one cycle after the request
// assumes optRdEn is a one-cycle pulse; optByte stands for what was programmed
`timescale 1ns/1ns
module fol_flash_model (
    input  wire logic        clock,
    input  wire logic        optRdEn,
    input  wire logic [15:0] optRdAddr,
    input  wire logic [7:0]  optByte,
    output logic [7:0]       arrRdata
);
    initial arrRdata = 8'h00;
    always @(posedge clock)
    begin
        if (optRdEn)
            arrRdata <= (optRdAddr == 16'h0000) ? optByte : 8'hFF;
        else
            arrRdata <= ~arrRdata; // released bus, no stale value
    end
endmodule

// >>> verification/testbench.sv
// bench for the flash command sequencer over axi4-lite
// assumes op counts shortened to 4 cycles
`timescale 1ns/1ns
module testbench;
    logic clock = 0, resetn = 0, shortReq = 0, stopReq = 0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid, optRdEn, cpuHoldReset;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [15:0] optRdAddr;
    logic [7:0] arrRdata, optByte = 8'hFB;
    fol_pkg::fol_arr_op_t arrOp;
    fol_pkg::fol_opt_t options;
    int errors = 0, cmpCount = 0;
    fol_flash_seq #(.PROG_CYCLES(4), .PAGE_ERASE_CYCLES(4), .MASS_ERASE_CYCLES(4)) fol_flash_seq_i (
        .clock(clock), .resetn(resetn), .shortResetReq(shortReq), .stopRecoverReq(stopReq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .arrOp(arrOp), .optRdEn(optRdEn), .optRdAddr(optRdAddr),
        .arrRdata(arrRdata), .options(options), .cpuHoldReset(cpuHoldReset));
    fol_flash_model fol_flash_model_i (.clock(clock), .optRdEn(optRdEn), .optRdAddr(optRdAddr),
        .optByte(optByte), .arrRdata(arrRdata));
    initial forever #4 clock = ~clock;
    task automatic end_sim();
        if (errors == 0 && cmpCount > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tmo();
        errors++;
        $display("CHECK FAILED %0t wait ran out", $time);
        end_sim();
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] v);
        int n;
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) break;
        end
        if (n == 40) tmo();
        // bready stays high so the response is accepted on the edge the loop breaks on, before a call right after this one starts
        r = bresp;
    endtask
    task automatic axr(input logic [11:0] a);
        int n;
        araddr <= a; arvalid <= 1; rready <= 1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) break;
        end
        if (n == 40) tmo();
        d = rdata;
    endtask
    // waits up to 30 cycles for the option load started by a reset request to finish
    task automatic waitLoad();
        int n;
        for (n = 0; n < 30 && cpuHoldReset !== 1'b0; n++) @(posedge clock);
        if (n == 30) tmo();
    endtask
    task automatic tLoad();
        waitLoad();
        chk(options, 5'b11100);
        axr(12'hFF8); chk(d, 32'h0000_0000);
    endtask
    task automatic tErase(input logic [7:0] code);
        int n;
        axw(12'hFF8, 32'h0000_0073); axw(12'hFF8, 32'h0000_008C);
        axr(12'hFF8); chk(d[1:0], 2'd2);
        axw(12'hFF8, {24'h0, code}); @(posedge clock);
        chk({arrOp.pageErase, arrOp.massErase}, (code == 8'h95) ? 2'b10 : 2'b01);
        axw(12'hFF8, 32'h0000_0073); axr(12'hFF8); chk(d[2], 1'b1);
        for (n = 0; n < 60 && (arrOp.pageErase | arrOp.massErase) !== 1'b0; n++) @(posedge clock);
        chk(n < 60, 1'b1);
        axr(12'hFF8); chk(d[2:0], 3'd0);
    endtask
    task automatic tProg();
        int n;
        axw(12'hFF8, 32'h0000_0073);
        axw(12'hFF8, 32'h0000_008C);
        axw(12'hFF0, 32'h0000_1234);
        axw(12'hFF4, 32'h0000_005A);
        chk(arrOp, {16'h1234, 8'h5A, 3'b100});
        for (n = 0; n < 60 && arrOp.prog !== 1'b0; n++) @(posedge clock);
        chk(n < 60, 1'b1);
        axr(12'hFF8);
        chk(d[2:0], 3'd2);
        axr(12'hFF0);
        chk(d, 32'h0000_1234);
        axw(12'hFF8, 32'h0000_0000);
        axr(12'hFF8);
        chk(d[1:0], 2'd0);
    endtask
    task automatic tBad();
        axw(12'hFF8, 32'h0000_0073); axw(12'hFF8, 32'h0000_0055);
        axr(12'hFF8); chk(d[1:0], 2'd0);
        axw(12'hFF8, 32'h0000_0095); @(posedge clock);
        chk(arrOp.pageErase, 1'b0);
        axr(12'hFF8); chk(d[3:0], 4'h0);
        axw(12'hFF8, 32'h0000_008C); axr(12'hFF8); chk(d[1:0], 2'd0);
        axw(12'h100, 32'h0000_00FF); chk(r, fol_pkg::RESP_SLVERR);
    endtask
    task automatic tReload();
        optByte <= 8'hE4; repeat (4) @(posedge clock);
        chk(options, 5'b11100);
        axw(12'hFF8, 32'h0000_0073); axw(12'hFF8, 32'h0000_008C);
        stopReq <= 1; repeat (2) @(posedge clock); stopReq <= 0; @(posedge clock);
        waitLoad();
        chk(options, 5'b00011);
        axr(12'hFF8); chk(d[1:0], 2'd0);
        axw(12'hFF8, 32'h0000_0073);
        axw(12'hFF8, 32'h0000_008C);
        axw(12'hFF8, 32'h0000_0095);
        axr(12'hFF8);
        chk(d, 32'h0000_0008);
        shortReq <= 1; optByte <= 8'hFB; repeat (2) @(posedge clock); shortReq <= 0;
        @(posedge clock);
        tLoad();
    endtask
    initial
    begin
        repeat (3) @(posedge clock);
        resetn <= 1;
        @(posedge clock);
        tLoad();
        tErase(8'h95);
        tErase(8'h63);
        tProg();
        tBad();
        tReload();
        end_sim();
    end
endmodule
